// ==== src/ext_irq_pkg.sv ====
// constants and types for the external request front end
// How it works
// - sense code 00: request while pin low
// - 01 falling, 10 rising, 11 both edges
// - level mode: flag set while pin low
// - edge modes: flag set on selected edges
// - clear needs prior read of set flag
// - level mode: handling clears flag if pin high
// - edge modes: handling clears flag
// - flag writes only clear, ones ignored
// - flags zero on reset and hardware standby
// - flag bits 7..3 read zero
// - nonmaskable request always forwarded, top priority
// - nonmaskable edge chosen by control bit
// - nonmaskable vector number is 4
// - channel vectors 7, 6, 5 for 2..0
// - detection ignores pin direction
// - flags set regardless of enable
// - request forwarded only while enabled
// - nonmaskable pin and enabled channel pins wake software standby
// - internal sources counted, handled elsewhere
// - edge bit 0 falling, 1 rising
// - enable bit 0 off, 1 on
package ext_irq_pkg;
  localparam int num_ch = 3;
  localparam logic [7:0] addr_sys_ctrl = 8'hc4;
  localparam logic [7:0] addr_enable = 8'hc2;
  localparam logic [7:0] addr_sense_hi = 8'hec;
  localparam logic [7:0] addr_sense_lo = 8'hed;
  localparam logic [7:0] addr_flags = 8'heb;
  localparam logic [7:0] sys_ctrl_reset = 8'h09;
  localparam logic [7:0] enable_reset = 8'hf8;
  localparam logic [7:0] sense_reset = 8'h00;
  localparam logic [7:0] flags_reset = 8'h00;
  localparam int nmi_edge_pos = 2;
  localparam logic [7:0] sys_ctrl_wmask = 8'hc7;
  localparam logic [7:0] enable_wmask = 8'h07;
  localparam logic [7:0] vec_nmi = 8'h04;
  localparam logic [7:0] vec_ch0 = 8'h05;
  // counts only; internal requests are resolved elsewhere
  localparam int internal_sources = 26;
  localparam int internal_sources_usb = 30;
  typedef enum logic [1:0] {
    sense_low = 2'h0,
    sense_fall = 2'h1,
    sense_rise = 2'h2,
    sense_both = 2'h3
  } sense_e;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;
endpackage : ext_irq_pkg

// ==== src/ext_irq_front.sv ====
// external request sensing, flags and vectors
`timescale 1ns/100ps
`default_nettype none
module ext_irq_front (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic hw_standby,
  input wire logic sw_standby,
  input wire ext_irq_pkg::reg_req_s req,
  output logic [7:0] rdata,
  input wire logic nmi_pin,
  input wire logic [2:0] irq_pin_n,
  input wire logic [2:0] ack_ch,
  input wire logic ack_nmi,
  output logic nmi_req,
  output logic [2:0] ch_req,
  output logic req_any,
  output logic [7:0] vector,
  output logic wake
);
  logic init;
  logic [2:0] s1_q, s2_q, s3_q;
  logic n1_q, n2_q, n3_q;
  logic [7:0] sys_q, en_q, shi_q, slo_q;
  logic [2:0] flag_q, flag_d, armed_q, armed_d;
  logic [2:0] set_ev;
  logic nmi_ev;
  logic nmi_pend_q;
  logic [2:0] fall, rise;

  // hardware standby reinitialises the same as reset; software standby does not
  assign init = srst | hw_standby;

  // two flops before any use; third holds previous sample
  always_ff @(posedge core_clk) begin
    if (init) begin
      s1_q <= 3'h7;
      s2_q <= 3'h7;
      s3_q <= 3'h7;
      n1_q <= 1'h1;
      n2_q <= 1'h1;
      n3_q <= 1'h1;
    end else begin
      s1_q <= irq_pin_n;
      s2_q <= s1_q;
      s3_q <= s2_q;
      n1_q <= nmi_pin;
      n2_q <= n1_q;
      n3_q <= n2_q;
    end
  end

  assign fall = s3_q & ~s2_q;
  assign rise = ~s3_q & s2_q;

  always_comb begin
    set_ev = 3'h0;
    for (int i = 0; i < 3; i++) begin
      case (ext_irq_pkg::sense_e'(slo_q[2*i +: 2]))
        ext_irq_pkg::sense_low: set_ev[i] = ~s2_q[i];
        ext_irq_pkg::sense_fall: set_ev[i] = fall[i];
        ext_irq_pkg::sense_rise: set_ev[i] = rise[i];
        ext_irq_pkg::sense_both: set_ev[i] = fall[i] | rise[i];
        default: set_ev[i] = 1'h0;
      endcase
    end
  end

  assign nmi_ev = sys_q[ext_irq_pkg::nmi_edge_pos] ? (~n3_q & n2_q)
                                                   : (n3_q & ~n2_q);

  always_ff @(posedge core_clk) begin
    if (init) begin
      sys_q <= ext_irq_pkg::sys_ctrl_reset;
      en_q <= ext_irq_pkg::enable_reset;
      shi_q <= ext_irq_pkg::sense_reset;
      slo_q <= ext_irq_pkg::sense_reset;
    end else if (req.wr) begin
      case (req.addr)
        ext_irq_pkg::addr_sys_ctrl:
          sys_q <= (sys_q & ~ext_irq_pkg::sys_ctrl_wmask) |
                   (req.wdata & ext_irq_pkg::sys_ctrl_wmask);
        ext_irq_pkg::addr_enable:
          en_q <= ext_irq_pkg::enable_reset |
                  (req.wdata & ext_irq_pkg::enable_wmask);
        ext_irq_pkg::addr_sense_hi: shi_q <= req.wdata;
        ext_irq_pkg::addr_sense_lo: slo_q <= req.wdata;
        default: sys_q <= sys_q;
      endcase
    end
  end

  // clear arms only when a read saw the flag at one
  always_comb begin
    flag_d = flag_q;
    armed_d = armed_q;
    if (req.rd && req.addr == ext_irq_pkg::addr_flags) begin
      armed_d = armed_q | flag_q;
    end
    for (int i = 0; i < 3; i++) begin
      if (req.wr && req.addr == ext_irq_pkg::addr_flags &&
          !req.wdata[i] && armed_q[i]) begin
        flag_d[i] = 1'h0;
        armed_d[i] = 1'h0;
      end
      if (ack_ch[i]) begin
        if (slo_q[2*i +: 2] != 2'h0) begin
          flag_d[i] = 1'h0;
        end else if (s2_q[i]) begin
          flag_d[i] = 1'h0;
        end
      end
      // set wins over any clear in the same cycle
      if (set_ev[i]) begin
        flag_d[i] = 1'h1;
      end
      if (!flag_d[i]) begin
        armed_d[i] = 1'h0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (init) begin
      flag_q <= 3'h0;
      armed_q <= 3'h0;
    end else begin
      flag_q <= flag_d;
      armed_q <= armed_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (init) begin
      nmi_pend_q <= 1'h0;
    end else if (nmi_ev) begin
      nmi_pend_q <= 1'h1;
    end else if (ack_nmi) begin
      nmi_pend_q <= 1'h0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (init) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        ext_irq_pkg::addr_sys_ctrl: rdata <= sys_q;
        ext_irq_pkg::addr_enable: rdata <= en_q;
        ext_irq_pkg::addr_sense_hi: rdata <= shi_q;
        ext_irq_pkg::addr_sense_lo: rdata <= slo_q;
        ext_irq_pkg::addr_flags: rdata <= {5'h00, flag_q};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // nmi first, then lowest channel; wider arbitration lives elsewhere
  always_ff @(posedge core_clk) begin
    if (init) begin
      nmi_req <= 1'h0;
      ch_req <= 3'h0;
      req_any <= 1'h0;
      vector <= 8'h00;
      wake <= 1'h0;
    end else begin
      nmi_req <= nmi_pend_q;
      ch_req <= flag_q & en_q[2:0];
      req_any <= nmi_pend_q | |(flag_q & en_q[2:0]);
      wake <= sw_standby & (nmi_pend_q | |(flag_q & en_q[2:0]));
      if (nmi_pend_q) begin
        vector <= ext_irq_pkg::vec_nmi;
      end else if (flag_q[0] & en_q[0]) begin
        vector <= ext_irq_pkg::vec_ch0;
      end else if (flag_q[1] & en_q[1]) begin
        vector <= ext_irq_pkg::vec_ch0 + 8'h01;
      end else if (flag_q[2] & en_q[2]) begin
        vector <= ext_irq_pkg::vec_ch0 + 8'h02;
      end else begin
        vector <= 8'h00;
      end
    end
  end
endmodule : ext_irq_front
`default_nettype wire

// ==== verif/ext_irq_front_sva.sv ====
// port assertions for the request front end
`timescale 1ns/100ps
`default_nettype none
module ext_irq_front_sva (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic hw_standby,
  input wire logic sw_standby,
  input wire ext_irq_pkg::reg_req_s req,
  input wire logic [7:0] rdata,
  input wire logic ack_nmi,
  input wire logic nmi_req,
  input wire logic [2:0] ch_req,
  input wire logic req_any,
  input wire logic [7:0] vector,
  input wire logic wake
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst || hw_standby);
  sequence rd_at(a);
    $past(req.rd) && $past(req.addr) == a;
  endsequence
  a_rdata_idle: assert property (
    !$past(req.rd) |-> rdata == 8'h00) else $error("stray rdata");
  a_flags_hi: assert property (
    rd_at(8'heb) |-> rdata[7:3] == 5'h00) else $error("flag msbs");
  a_enable_hi: assert property (
    rd_at(8'hc2) |-> rdata[7:3] == 5'h1f) else $error("enable msbs");
  a_vec_nmi: assert property (
    nmi_req |-> vector == 8'h04) else $error("nmi vector");
  a_vec_chan: assert property (
    !nmi_req && ch_req != 3'h0 |-> vector == (ch_req[0] ? 8'h05 :
    (ch_req[1] ? 8'h06 : 8'h07))) else $error("channel vector");
  a_any_or: assert property (
    req_any == (nmi_req || ch_req != 3'h0)) else $error("req_any");
  a_wake_gate: assert property (
    wake == ($past(sw_standby) && req_any)) else $error("wake mismatch");
  a_nmi_hold: assert property (
    nmi_req && !ack_nmi && !$past(ack_nmi) |=> nmi_req)
    else $error("nmi lost");
endmodule : ext_irq_front_sva
`default_nettype wire

// ==== verif/irq_source_model.sv ====
// far-side sources: pins held as plain inputs
`timescale 1ns/100ps
`default_nettype none
module irq_source_model (
  input wire logic core_clk,
  input wire logic [3:0] level,
  output var logic nmi_pin,
  output var logic [2:0] irq_pin_n
);
  initial {nmi_pin, irq_pin_n} = 4'hf;
  // never shared with another function
  always @(posedge core_clk) {nmi_pin, irq_pin_n} <= level;
endmodule : irq_source_model
`default_nettype wire

// ==== verif/test_ext_irq_front.sv ====
// self-checking bench for the request front end
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module test_ext_irq_front;
  logic core_clk = 0, srst = 1, hw_standby = 0, sw_standby = 0;
  logic ack_nmi = 0, nmi_pin, nmi_req, req_any, wake;
  logic [2:0] ack_ch = 0, irq_pin_n, ch_req;
  logic [3:0] level = 4'hf;
  logic [7:0] rdata, vector, en;
  ext_irq_pkg::reg_req_s req = '0;
  int failures = 0, num_checks = 0, cyc = 0, e, c;
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (++cyc == 5000) begin
    failures++;
    end_of_test();
  end
  ext_irq_front i_dut (.*);
  irq_source_model i_src (.*);
  task automatic bus(input logic [7:0] a, d, input logic w);
    @(posedge core_clk) req <= '{a, d, w, !w};
    @(posedge core_clk) req <= '0;
  endtask : bus
  task automatic rd(input logic [7:0] a, x);
    bus(a, 8'h00, 1'b0);
    #1 `CHK(rdata, x)
  endtask : rd
  // pins and acks together; waits out sync plus flag latency
  task automatic step(input logic [3:0] p, ack);
    @(posedge core_clk) begin
      level <= p;
      {ack_nmi, ack_ch} <= ack;
    end
    @(posedge core_clk) {ack_nmi, ack_ch} <= 4'h0;
    repeat (7) @(posedge core_clk);
    #1;
  endtask : step
  task automatic end_of_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test
  initial begin
    void'($urandom(68));
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    rd(8'hc2, 8'hf8);
    rd(8'h10, 8'h00);
    for (int m = 0; m < 4; m++) begin
      c = m % 3;
      en = 8'($urandom % 8);
      bus(8'hc2, en, 1'b1);
      bus(8'hed, 8'(m << (2 * c)), 1'b1);
      step(4'hf ^ 4'(1 << c), 4'h0);
      e = (m != 2);
      bus(8'heb, 8'h00, 1'b1);
      bus(8'heb, 8'hff, 1'b1);
      rd(8'heb, 8'(e << c));
      `CHK(ch_req, 3'(e && en[c]) << c)
      `CHK(vector, (e && en[c]) ? 8'(5 + c) : 8'h00)
      step(4'hf, 4'h0);
      e = e | (m >= 2);
      rd(8'heb, 8'(e << c));
      if (m % 2) bus(8'heb, 8'h00, 1'b1);
      else step(4'hf, 4'(1 << c));
      rd(8'heb, 8'h00);
    end
    step(4'h7, 4'h0);
    `CHK(vector, 8'h04)
    `CHK(req_any, 1'b1)
    @(posedge core_clk) sw_standby <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1 `CHK(wake, 1'b1)
    step(4'h7, 4'h8);
    `CHK(nmi_req, 1'b0)
    bus(8'hc4, 8'h0d, 1'b1);
    step(4'hf, 4'h0);
    `CHK(nmi_req, 1'b1)
    // mid-run standby must reinitialise like reset
    bus(8'heb, 8'h00, 1'b1);
    step(4'hf ^ 4'h1, 4'h0);
    @(posedge core_clk) hw_standby <= 1'b1;
    repeat (2) @(posedge core_clk);
    hw_standby <= 1'b0;
    #1 `CHK(nmi_req, 1'b0)
    `CHK(req_any, 1'b0)
    `CHK(wake, 1'b0)
    rd(8'hc4, 8'h09);
    rd(8'hc2, 8'hf8);
    rd(8'hed, 8'h00);
    rd(8'heb, 8'h01);
    end_of_test();
  end
endmodule : test_ext_irq_front
bind ext_irq_front ext_irq_front_sva i_sva (.*);
`default_nettype wire
